// [logic/pmic_power_state_control.sv]
// Power-state controller top
`timescale 1ns/1ps

// Behaviour
// - Active: button fall pulses wake five ticks
// - Long button hold drops main rails, recovery
// - Restart after 500 ms; a hold firing during the wait restarts the 500 ms
// - Continued hold repeats reset every interval
// - Charger falling edge or tied low wakes
// - Debounce button 50 ms, charger 10 ms
// - Active: button change interrupt, level status
// - Active: charger change interrupt, level status
// - Any event sets flag, pulls interrupt low
// - Reading interrupt register clears, releases pin
// - Persisting fault re-asserts within 32 us
// - Masks gate pin only, not flags
// - Slave address 0x24, register auto-increment
// - Acknowledge address, register, data bytes
// - Write completes on each data word
// - Off: rails off, registers default, bus off
// - Leave off on bias good plus wake
// - Off on power fail, or request low with all rails sequenced
// - Wake: rails on, wake low, 20 s timeout
// - Request low: sequence down, suspend, reset regs
// - Suspend returns active on request, to wake state on wake
// - Reset/fault: main rails off, backup on, recover when overtemp clear
// - Button change interrupt has own mask
module pmic_power_state_control
    import pmic_pkg::*;
#(
    parameter logic [TW-1:0] HOLD_SHORT_TICKS = TW'(HOLD_SHORT_S * SLOW_HZ),
    parameter logic [TW-1:0] HOLD_LONG_TICKS = TW'(HOLD_LONG_S * SLOW_HZ),
    parameter logic [TW-1:0] WAIT_REQ_TICKS = TW'(WAIT_REQ_S * SLOW_HZ),
    parameter logic [TW-1:0] SEQ_DOWN_TICKS =
        TW'(SEQ_DOWN_MS * SLOW_HZ / 1000)
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins from outside the clock domain
    input wire logic push_button_pin,
    input wire logic charger_detect_in,
    input wire logic power_request_in,
    input wire logic powerfail_sense,
    input wire logic rail_good,
    input wire logic overtemp_fault,
    input wire logic bias_ok,
    // Configuration bits
    input wire logic long_hold_select,
    input wire logic powerfail_off_enable,
    input wire logic all_rails_sequenced,
    input wire logic button_irq_mask,
    input wire logic charger_irq_mask,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Open-drain outputs
    output logic host_wake_out_n,
    output logic host_wake_oe,
    output logic irq_out_n,
    output logic irq_oe,
    // Rails and status
    output logic seq_rails_en,
    output logic unseq_rails_en,
    output logic backup_rails_en,
    output logic regs_default,
    output logic button_level_flag,
    output logic charger_level_flag,
    output logic [IRQ_W-1:0] irq_flags,
    output power_state_t power_state,
    // Register access toward the rest of the device
    input wire logic [7:0] ext_rdata,
    output logic [7:0] reg_rd_ptr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr_strobe,
    output logic reg_rd_strobe
);

    // ****************************************************************
    // Input synchronisers and slow tick
    // ****************************************************************
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] meta;
    logic [NSYNC-1:0] sync;
    logic [NSYNC-1:0] sync_d;
    logic [DIV_W-1:0] div_cnt;
    logic tick;

    assign raw = {sda_in, scl_in, bias_ok, overtemp_fault, rail_good,
                  powerfail_sense, power_request_in, charger_detect_in,
                  push_button_pin};

    generate
        for (genvar i = 0; i < NSYNC; i++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    {sync_d[i], sync[i], meta[i]} <= 3'h0;
                end
                else
                begin
                    {sync_d[i], sync[i], meta[i]} <=
                        {sync[i], meta[i], raw[i]};
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rst_n || div_cnt == TICK_LAST)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + DIV_W'(1);
    end

    assign tick = (div_cnt == TICK_LAST);

    // ****************************************************************
    // Debounce and hold timing
    // ****************************************************************
    function automatic logic [TW-1:0] db_step(input logic [TW-1:0] cnt,
        input logic low, input logic [TW-1:0] limit);
        logic [TW-1:0] r;
        r = cnt;
        if (!low)
            r = '0;
        else if (tick && cnt != limit)
            r = cnt + TW'(1);
        return r;
    endfunction

    logic [TW-1:0] btn_db_cnt;
    logic [TW-1:0] chg_db_cnt;
    logic btn_db;
    logic chg_db;
    logic btn_db_d;
    logic chg_db_d;
    logic wake_ev;
    logic [TW-1:0] hold_cnt;
    logic [TW-1:0] hold_limit;
    logic hold_fire;
    logic btn_fall;

    assign btn_db = (btn_db_cnt == BTN_DB_TICKS);
    assign chg_db = (chg_db_cnt == CHG_DB_TICKS);
    // A charger tied low debounces once after reset and wakes the part
    assign wake_ev = (btn_db && !btn_db_d) || (chg_db && !chg_db_d)
                     || sync[SI_PREQ];
    assign hold_limit = long_hold_select ? HOLD_LONG_TICKS
                                         : HOLD_SHORT_TICKS;
    assign hold_fire = tick && hold_cnt >= hold_limit - TW'(1);
    assign btn_fall = sync_d[SI_BTN] && !sync[SI_BTN];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            btn_db_cnt <= '0;
            chg_db_cnt <= '0;
            btn_db_d <= 1'b0;
            chg_db_d <= 1'b0;
        end
        else
        begin
            btn_db_cnt <= db_step(btn_db_cnt, !sync[SI_BTN],
                                  BTN_DB_TICKS);
            chg_db_cnt <= db_step(chg_db_cnt, !sync[SI_CHG],
                                  CHG_DB_TICKS);
            btn_db_d <= btn_db;
            chg_db_d <= chg_db;
        end
    end

    // Restarts after each firing so a stuck button keeps cycling
    always_ff @(posedge clk)
    begin
        if (!rst_n || sync[SI_BTN] || power_state == ST_OFF || hold_fire)
            hold_cnt <= '0;
        else if (tick)
            hold_cnt <= hold_cnt + TW'(1);
    end

    // ****************************************************************
    // Power-state sequencing
    // ****************************************************************
    power_state_t next_state;
    logic [TW-1:0] stimer;
    logic down_to_off;
    logic pf_off;
    logic fault;

    assign pf_off = powerfail_off_enable && !sync[SI_PFS];
    assign fault = !sync[SI_RGOOD] || sync[SI_OTEMP];

    always_comb
    begin
        next_state = power_state;
        case (power_state)
            ST_OFF:
                if (sync[SI_BIAS] && wake_ev)
                    next_state = ST_WAIT_REQ;
            ST_WAIT_REQ:
                if (hold_fire)
                    next_state = ST_RESET_SEQ;
                else if (pf_off)
                    next_state = ST_SEQ_DOWN;
                else if (sync[SI_PREQ])
                    next_state = ST_ACTIVE;
                else if (tick && stimer >= WAIT_REQ_TICKS - TW'(1))
                    next_state = ST_OFF;
            ST_ACTIVE:
                if (hold_fire || fault)
                    next_state = ST_RESET_SEQ;
                else if (pf_off || !sync[SI_PREQ])
                    next_state = ST_SEQ_DOWN;
            ST_SEQ_DOWN:
                if (tick && stimer >= SEQ_DOWN_TICKS - TW'(1))
                    next_state = down_to_off ? ST_OFF : ST_SUSPEND;
            ST_SUSPEND:
                if (pf_off)
                    next_state = ST_SEQ_DOWN;
                else if (sync[SI_PREQ])
                    next_state = ST_ACTIVE;
                else if (wake_ev)
                    next_state = ST_WAIT_REQ;
            ST_RESET_SEQ:
                if (tick && stimer >= SEQ_DOWN_TICKS - TW'(1))
                    next_state = ST_RECOVERY;
            ST_RECOVERY:
                if (hold_fire)
                    next_state = ST_RESET_SEQ;
                else if (!sync[SI_OTEMP])
                    next_state = ST_ACTIVE;
            default:
                next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            power_state <= ST_OFF;
        else
            power_state <= next_state;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || next_state != power_state
            || (power_state == ST_RESET_SEQ && hold_fire))
            stimer <= '0;
        else if (tick)
            stimer <= stimer + TW'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            down_to_off <= 1'b0;
        else if (next_state == ST_SEQ_DOWN && power_state != ST_SEQ_DOWN)
            down_to_off <= all_rails_sequenced || pf_off;
    end

    // ****************************************************************
    // Rails and register defaults
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            seq_rails_en <= 1'b0;
            unseq_rails_en <= 1'b0;
            backup_rails_en <= 1'b0;
            regs_default <= 1'b1;
        end
        else
        begin
            seq_rails_en <= power_state == ST_WAIT_REQ
                            || power_state == ST_ACTIVE;
            case (power_state)
                ST_WAIT_REQ, ST_ACTIVE:
                    unseq_rails_en <= 1'b1;
                ST_SEQ_DOWN:
                    unseq_rails_en <= unseq_rails_en && !down_to_off;
                ST_SUSPEND:
                    unseq_rails_en <= unseq_rails_en;
                default:
                    unseq_rails_en <= 1'b0;
            endcase
            backup_rails_en <= power_state != ST_OFF;
            regs_default <= power_state == ST_OFF
                || power_state == ST_RESET_SEQ
                || (power_state == ST_SEQ_DOWN
                    && next_state == ST_SUSPEND);
        end
    end

    // ****************************************************************
    // Wake pin
    // ****************************************************************
    logic [2:0] wake_cnt;

    always_ff @(posedge clk)
    begin
        if (!rst_n || power_state != ST_ACTIVE)
            wake_cnt <= '0;
        else if (btn_fall)
            wake_cnt <= WAKE_TICKS;
        else if (tick && wake_cnt != 3'h0)
            wake_cnt <= wake_cnt - 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            host_wake_out_n <= 1'b1;
            host_wake_oe <= 1'b0;
        end
        else
        begin
            // Held low until the host raises its power request
            host_wake_oe <= (power_state == ST_WAIT_REQ
                             && !sync[SI_PREQ])
                            || wake_cnt != 3'h0;
            host_wake_out_n <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt flags and pin
    // ****************************************************************
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_mask_vec;
    logic irq_read;
    logic active;
    logic [7:0] rdata;

    assign active = power_state == ST_ACTIVE;
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_BTN] = active && (sync[SI_BTN] != sync_d[SI_BTN]);
        irq_set[IRQ_CHG] = active && (sync[SI_CHG] != sync_d[SI_CHG]);
        irq_set[IRQ_RAIL] = active && !sync[SI_RGOOD];
        irq_set[IRQ_TEMP] = power_state != ST_OFF && sync[SI_OTEMP];
        irq_mask_vec = '0;
        irq_mask_vec[IRQ_BTN] = button_irq_mask;
        irq_mask_vec[IRQ_CHG] = charger_irq_mask;
    end

    assign irq_read = reg_rd_strobe && reg_addr == IRQ_REG_ADDR;
    assign rdata = (reg_rd_ptr == IRQ_REG_ADDR) ? 8'(irq_flags) : ext_rdata;

    // Set wins over the read-clear, so a lasting fault stays flagged
    always_ff @(posedge clk)
    begin
        if (!rst_n || power_state == ST_OFF)
            irq_flags <= '0;
        else
            irq_flags <= (irq_flags & ~{IRQ_W{irq_read}})
                         | irq_set;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_out_n <= 1'b1;
            irq_oe <= 1'b0;
        end
        else
        begin
            irq_out_n <= 1'b0;
            irq_oe <= |(irq_flags & ~irq_mask_vec);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            button_level_flag <= 1'b0;
            charger_level_flag <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            button_level_flag <= sync[SI_BTN];
            charger_level_flag <= sync[SI_CHG];
            sda_out <= 1'b0;
        end
    end

    // ****************************************************************
    // Register slave
    // ****************************************************************
    serial_reg_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .enable(power_state != ST_OFF),
        .scl(sync[SI_SCL]),
        .sda(sync[SI_SDA]),
        .sda_oe(sda_oe),
        .rdata(rdata),
        .ptr(reg_rd_ptr),
        .acc_addr(reg_addr),
        .wdata(reg_wdata),
        .wr_pulse(reg_wr_strobe),
        .rd_pulse(reg_rd_strobe)
    );

endmodule // pmic_power_state_control

// [logic/pmic_pkg.sv]
// Shared constants and types for the power-state controller
package pmic_pkg;

    // ****************************************************************
    // Clocking and timing
    // ****************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int SLOW_HZ = 32_768;
    localparam int TICK_DIV = CLK_HZ / SLOW_HZ;
    localparam int DIV_W = 11;
    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_DIV - 1);
    localparam int TW = 20;

    localparam int HOLD_SHORT_S = 8;
    localparam int HOLD_LONG_S = 15;
    localparam int WAIT_REQ_S = 20;
    localparam int SEQ_DOWN_MS = 500;
    localparam int BTN_DB_MS = 50;
    localparam int CHG_DB_MS = 10;
    localparam int WAKE_PULSE_TICKS = 5;

    // Least times round up to whole slow ticks
    localparam logic [TW-1:0] BTN_DB_TICKS =
        TW'((BTN_DB_MS * SLOW_HZ + 999) / 1000);
    localparam logic [TW-1:0] CHG_DB_TICKS =
        TW'((CHG_DB_MS * SLOW_HZ + 999) / 1000);
    localparam logic [2:0] WAKE_TICKS = 3'(WAKE_PULSE_TICKS);

    // ****************************************************************
    // Synchroniser slots
    // ****************************************************************
    localparam int NSYNC = 9;
    localparam int SI_BTN = 0;
    localparam int SI_CHG = 1;
    localparam int SI_PREQ = 2;
    localparam int SI_PFS = 3;
    localparam int SI_RGOOD = 4;
    localparam int SI_OTEMP = 5;
    localparam int SI_BIAS = 6;
    localparam int SI_SCL = 7;
    localparam int SI_SDA = 8;

    // ****************************************************************
    // Interrupt flags and serial interface
    // ****************************************************************
    localparam int IRQ_W = 4;
    localparam int IRQ_BTN = 0;
    localparam int IRQ_CHG = 1;
    localparam int IRQ_RAIL = 2;
    localparam int IRQ_TEMP = 3;
    localparam logic [7:0] IRQ_REG_ADDR = 8'h01;
    localparam logic [6:0] SLAVE_ADDR = 7'h24;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT_REQ,
        ST_ACTIVE,
        ST_SEQ_DOWN,
        ST_SUSPEND,
        ST_RESET_SEQ,
        ST_RECOVERY
    } power_state_t;

    typedef enum logic [2:0] {
        I_IDLE,
        I_ADDR,
        I_REG,
        I_WR,
        I_RD,
        I_ACK,
        I_RACK
    } i2c_state_t;

endpackage

// [logic/serial_reg_slave.sv]
// Two-wire register slave with address auto-increment
`timescale 1ns/1ps

module serial_reg_slave
    import pmic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    // Synchronised bus lines
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    // Register access
    input wire logic [7:0] rdata,
    output logic [7:0] ptr,
    output logic [7:0] acc_addr,
    output logic [7:0] wdata,
    output logic wr_pulse,
    output logic rd_pulse
);

    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    i2c_state_t st;
    i2c_state_t nxt;
    logic start_c;
    logic stop_c;
    logic rise;
    logic fall;

    assign start_c = scl && scl_d && sda_d && !sda;
    assign stop_c = scl && scl_d && !sda_d && sda;
    assign rise = scl && !scl_d;
    assign fall = !scl && scl_d;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || !enable || stop_c)
        begin
            st <= I_IDLE;
            nxt <= I_IDLE;
            sda_oe <= 1'b0;
            bitcnt <= '0;
            shreg <= '0;
            wr_pulse <= 1'b0;
            rd_pulse <= 1'b0;
            if (!rst_n || !enable)
            begin
                ptr <= '0;
                acc_addr <= '0;
                wdata <= '0;
            end
        end
        else if (start_c)
        begin
            st <= I_ADDR;
            sda_oe <= 1'b0;
            bitcnt <= '0;
            wr_pulse <= 1'b0;
            rd_pulse <= 1'b0;
        end
        else
        begin
            wr_pulse <= 1'b0;
            rd_pulse <= 1'b0;
            if (rise)
            begin
                if (st == I_ADDR || st == I_REG || st == I_WR)
                begin
                    shreg <= {shreg[6:0], sda};
                    bitcnt <= bitcnt + 4'h1;
                end
                else if (st == I_RACK)
                begin
                    // A not-acknowledge ends the read burst
                    st <= sda ? I_IDLE : I_ACK;
                    nxt <= I_RD;
                end
            end
            else if (fall)
            begin
                case (st)
                    I_ADDR, I_REG, I_WR:
                    begin
                        if (bitcnt == BYTE_BITS)
                        begin
                            bitcnt <= '0;
                            sda_oe <= 1'b1;
                            st <= I_ACK;
                            if (st == I_ADDR)
                            begin
                                if (shreg[7:1] != SLAVE_ADDR)
                                begin
                                    sda_oe <= 1'b0;
                                    st <= I_IDLE;
                                end
                                nxt <= shreg[0] ? I_RD : I_REG;
                            end
                            else if (st == I_REG)
                            begin
                                ptr <= shreg;
                                nxt <= I_WR;
                            end
                            else
                            begin
                                // Each data word completes a write
                                wdata <= shreg;
                                acc_addr <= ptr;
                                ptr <= ptr + 8'h01;
                                wr_pulse <= 1'b1;
                                nxt <= I_WR;
                            end
                        end
                    end
                    I_ACK:
                    begin
                        sda_oe <= 1'b0;
                        st <= nxt;
                        if (nxt == I_RD)
                        begin
                            sda_oe <= !rdata[7];
                            shreg <= {rdata[6:0], 1'b0};
                            bitcnt <= 4'h1;
                            acc_addr <= ptr;
                            ptr <= ptr + 8'h01;
                            rd_pulse <= 1'b1;
                        end
                    end
                    I_RD:
                    begin
                        if (bitcnt == BYTE_BITS)
                        begin
                            sda_oe <= 1'b0;
                            st <= I_RACK;
                        end
                        else
                        begin
                            sda_oe <= !shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

endmodule // serial_reg_slave

// [tb/pmic_power_state_control_chk.sv]
// Port assertions for the controller
`timescale 1ns/1ps
module pmic_power_state_control_chk
    import pmic_pkg::*;
(
    // Clock, reset and pins
    input logic clk, rst_n, push_button_pin, power_request_in,
    input logic rail_good, bias_ok, button_irq_mask, charger_irq_mask,
    // Outputs watched
    input logic sda_oe, host_wake_oe, irq_oe, seq_rails_en,
    input logic unseq_rails_en, backup_rails_en, button_level_flag,
    input logic [IRQ_W-1:0] irq_flags,
    input power_state_t power_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_off;
        power_state == ST_OFF ##1 power_state == ST_OFF;
    endsequence
    sequence s_reset;
        power_state == ST_RESET_SEQ ##1 power_state == ST_RESET_SEQ;
    endsequence
    a_off_quiet: assert property (s_off |->
        !seq_rails_en && !sda_oe) else $error("rail or bus on in off");
    a_reset_rails: assert property (s_reset |->
        !seq_rails_en && !unseq_rails_en && backup_rails_en)
        else $error("rails wrong in reset");
    a_wake_start: assert property (power_state == ST_ACTIVE &&
        $fell(button_level_flag) |-> ##[0:4] host_wake_oe)
        else $error("no wake pulse");
    a_irq_set: assert property ((irq_flags &
        {2'b11, ~charger_irq_mask, ~button_irq_mask}) != 4'h0 |=> irq_oe)
        else $error("irq pin not pulled");
    a_irq_masked: assert property ((irq_flags &
        {2'b11, ~charger_irq_mask, ~button_irq_mask}) == 4'h0 |=> !irq_oe)
        else $error("irq pin pulled");
    a_button_level: assert property (
        push_button_pin [*5] |-> button_level_flag) else $error("stale");
    a_fault_reset: assert property (
        (power_state == ST_ACTIVE && !rail_good) [*2]
        |-> ##[1:3] power_state == ST_RESET_SEQ) else $error("no reset");
    a_request_wake: assert property (
        (power_state == ST_OFF && bias_ok && power_request_in) [*5]
        |-> ##[0:2] power_state != ST_OFF) else $error("no wake");
endmodule // pmic_power_state_control_chk

bind pmic_power_state_control pmic_power_state_control_chk
    u_pmic_power_state_control_chk (.*);

// [tb/host_model.sv]
// Host model: power request pin and two-wire bus master
`timescale 1ns/1ps
module host_model
(
    input logic sda_oe,
    output logic power_request_in = 1'b0,
    output logic scl_in = 1'b1,
    output logic sda_in
);
    logic sda_m = 1'b1;
    // Pulled-up line, low when either side pulls
    assign sda_in = sda_m & ~sda_oe;
    task automatic set_req(input logic v);
        power_request_in = v;
    endtask
    // Data moves while the clock is low, save at start and stop
    task automatic ph(input logic c, input logic d);
        scl_in = c;
        #100 sda_m = d;
        #525;
    endtask
    task automatic cond(input logic [5:0] p);
        for (int i = 4; i >= 0; i -= 2)
            ph(p[i+1], p[i]);
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            ph(1'b0, d[i]);
            ph(1'b1, d[i]);
            r[i] = sda_in;
            ph(1'b1, d[i]);
            ph(1'b0, d[i]);
        end
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q,
        output logic ok);
        logic [8:0] r0, r1, r2, r3;
        cond(6'h1E);
        xfer({7'h24, 1'b0, 1'b1}, r0);
        xfer({a, 1'b1}, r1);
        cond(6'h1E);
        xfer({7'h24, 1'b1, 1'b1}, r2);
        xfer(9'h1FF, r3);
        cond(6'h0B);
        q = r3[8:1];
        ok = !(r0[0] | r1[0] | r2[0]);
    endtask
endmodule // host_model

// [tb/pmic_power_state_control_test.sv]
// Bench for the power-state controller
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    n_mismatch++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module pmic_power_state_control_test
    import pmic_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, bias_ok = 1'b0, rail_good = 1'b1;
    logic push_button_pin = 1'b1, charger_detect_in = 1'b1, ok;
    logic powerfail_sense = 1'b1, overtemp_fault = 1'b0;
    logic long_hold_select = 1'b0, powerfail_off_enable = 1'b0;
    logic all_rails_sequenced = 1'b0, button_irq_mask = 1'b0;
    logic charger_irq_mask = 1'b0, sda_out, irq_oe, irq_out_n;
    logic [7:0] ext_rdata = 8'h00, q, reg_rd_ptr, reg_addr, reg_wdata;
    logic power_request_in, scl_in, sda_in, sda_oe, regs_default;
    logic host_wake_out_n, host_wake_oe, reg_wr_strobe, reg_rd_strobe;
    logic seq_rails_en, unseq_rails_en, backup_rails_en;
    logic button_level_flag, charger_level_flag;
    logic [IRQ_W-1:0] irq_flags;
    power_state_t power_state;
    int n_mismatch = 0, comparisons = 0;
    // Short holds keep the run small
    pmic_power_state_control #(.HOLD_SHORT_TICKS(TW'(8)),
        .HOLD_LONG_TICKS(TW'(12)), .WAIT_REQ_TICKS(TW'(16)),
        .SEQ_DOWN_TICKS(TW'(4))) u_pmic_power_state_control (.*);
    host_model u_host_model (.*);
    always #10 clk = ~clk;
    task automatic clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_state(input power_state_t s);
        for (int i = 0; i < 20 * TICK_DIV && power_state !== s; i++)
            @(posedge clk);
        #1;
        `CHK(power_state, s)
    endtask
    task automatic t_wake_pulse();
        push_button_pin = 1'b0;
        clks(5);
        `CHK({host_wake_oe, irq_oe, button_level_flag}, 3'h6)
        clks(3 * TICK_DIV);
        `CHK(host_wake_oe, 1'b1)
        clks(3 * TICK_DIV);
        `CHK(host_wake_oe, 1'b0)
        push_button_pin = 1'b1;
        u_host_model.rd_reg(8'h01, q, ok);
        `CHK({ok, q}, 9'h101)
        clks(3);
        `CHK({irq_oe, irq_flags}, 5'h00)
    endtask
    task automatic t_mask();
        {button_irq_mask, charger_irq_mask} = 2'h3;
        {push_button_pin, charger_detect_in} = 2'h0;
        clks(5);
        `CHK({irq_oe, irq_flags}, 5'h03)
        {push_button_pin, charger_detect_in} = 2'h3;
        u_host_model.rd_reg(8'h01, q, ok);
        `CHK(q, 8'h03)
        {button_irq_mask, charger_irq_mask} = 2'h0;
    endtask
    task automatic t_fault();
        rail_good = 1'b0;
        clks(6);
        `CHK(power_state, ST_RESET_SEQ)
        rail_good = 1'b1;
        clks(2);
        `CHK({seq_rails_en, unseq_rails_en, backup_rails_en}, 3'h1)
        wait_state(ST_ACTIVE);
    endtask
    task automatic t_hold();
        push_button_pin = 1'b0;
        clks(7 * TICK_DIV);
        `CHK(power_state, ST_ACTIVE)
        wait_state(ST_RESET_SEQ);
        wait_state(ST_ACTIVE);
        wait_state(ST_RESET_SEQ);
        push_button_pin = 1'b1;
        wait_state(ST_ACTIVE);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clks(12);
        rst_n = 1'b1;
        clks(3);
        bias_ok = 1'b1;
        u_host_model.set_req(1'b1);
        wait_state(ST_ACTIVE);
        clks(8);
        `CHK({host_wake_oe, seq_rails_en, backup_rails_en}, 3'h3)
        t_wake_pulse();
        t_mask();
        u_host_model.set_req(1'b0);
        wait_state(ST_SUSPEND);
        `CHK(seq_rails_en, 1'b0)
        u_host_model.set_req(1'b1);
        wait_state(ST_ACTIVE);
        t_fault();
        t_hold();
        end_of_test();
    end
    initial
    begin
        #1_800_000;
        n_mismatch++;
        end_of_test();
    end
endmodule // pmic_power_state_control_test
